// >>> src/ptsd_pkg.sv
// Shared constants and types of the potentiometer transfer/step link.
package ptsd_pkg;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned NUM_POTS = 4;
  localparam int unsigned NUM_SLOTS = 4;
  localparam int unsigned WIPER_W = 6;
  localparam logic [5:0] WIPER_RST = 6'h00;
  localparam logic [5:0] WIPER_MAX = 6'h3f;
  localparam logic [5:0] ADDR_FIXED = 6'h14;
  localparam logic [3:0] OP_GRESTORE = 4'h1;
  localparam logic [3:0] OP_GSAVE = 4'h8;
  localparam logic [3:0] OP_SAVE = 4'he;
  localparam logic [3:0] OP_RESTORE = 4'hd;
  localparam logic [5:0] OP_STEP = 6'h08;
  localparam logic [2:0] BIT_LAST = 3'h7;
  // Write-cycle time is not fixed by the link; a plain default is used.
  localparam int unsigned T_WR_NS = 5000000;
  localparam int unsigned T_WR_CYC_DEF =
    (T_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] SCLK_HALF_CYC = 2'h2;
  localparam logic [2:0] CS_GAP_CYC = 3'h4;
  localparam logic [3:0] REG_FRAME = 4'h0;
  localparam logic [3:0] REG_STEPS = 4'h4;
  localparam logic [3:0] REG_CFG = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hc;
  localparam logic [12:0] FRAME_RST = 13'h0000;
  localparam logic [31:0] STEPS_RST = 32'h0000_0000;
  localparam logic [1:0] CFG_RST = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {DS_ADDR, DS_INSTR, DS_STEP, DS_SKIP} ptsd_dst_t;
  typedef enum logic [1:0] {HS_IDLE, HS_SHIFT, HS_GAP} ptsd_hst_t;
endpackage

// >>> src/ptsd_spi_if.sv
// Serial link between the host controller and the potentiometer device.
`timescale 1ns/1ns
interface ptsd_spi_if;
  logic cs_n;
  logic sclk;
  logic si;
  modport dev (input cs_n, input sclk, input si);
  modport host (output cs_n, output sclk, output si);
endinterface

// >>> src/ptsd_device.sv
// Device end: decodes transfer and step frames, holds wipers and slots.
`timescale 1ns/1ns
module ptsd_device
  import ptsd_pkg::*;
#(
  parameter int unsigned T_WR_CYC = T_WR_CYC_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  ptsd_spi_if.dev spi,
  input wire logic addr_pin_hi,
  input wire logic addr_pin_lo,
  output logic [NUM_POTS*WIPER_W-1:0] live_wiper_setting,
  output logic [NUM_POTS*NUM_SLOTS*WIPER_W-1:0] stored_setting_slot,
  output logic programming_busy_flag
);
  localparam logic [31:0] T_WR_LOAD = 32'(T_WR_CYC - 1);

  ptsd_dst_t st_q;
  ptsd_dst_t st_d;
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic [6:0] sh_q;
  logic [6:0] sh_d;
  logic [7:0] instr_q;
  logic [7:0] instr_d;
  logic have_q;
  logic have_d;
  logic sclk_q;
  logic csn_q;
  logic [NUM_POTS-1:0][WIPER_W-1:0] wiper_q;
  logic [NUM_POTS-1:0][WIPER_W-1:0] wiper_d;
  logic [NUM_POTS-1:0][NUM_SLOTS-1:0][WIPER_W-1:0] slot_q;
  logic [NUM_POTS-1:0][NUM_SLOTS-1:0][WIPER_W-1:0] slot_d;
  logic busy_q;
  logic busy_d;
  logic [31:0] bcnt_q;
  logic [31:0] bcnt_d;

  logic sclk_rise;
  logic cs_rise;
  logic [7:0] byte_v;
  logic [1:0] rr;
  logic [1:0] pp;
  logic [1:0] step_pp;

  // Chip select and serial clock are sampled on aclk; edges come from the last sample.
  assign sclk_rise = spi.sclk & ~sclk_q;
  assign cs_rise = spi.cs_n & ~csn_q;
  assign byte_v = {sh_q, spi.si};
  assign rr = instr_q[3:2];
  assign pp = instr_q[1:0];
  assign step_pp = instr_q[1:0];

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    instr_d = instr_q;
    have_d = have_q;
    wiper_d = wiper_q;
    slot_d = slot_q;
    busy_d = busy_q;
    bcnt_d = bcnt_q;

    if (busy_q) begin
      if (bcnt_q == 32'h0000_0000) begin
        busy_d = 1'b0;
      end else begin
        bcnt_d = bcnt_q - 32'h0000_0001;
      end
    end

    if (spi.cs_n) begin
      st_d = DS_ADDR;
      cnt_d = 3'h0;
      have_d = 1'b0;
    end else if (sclk_rise) begin
      cnt_d = cnt_q + 3'h1;
      sh_d = byte_v[6:0];
      case (st_q)
        DS_ADDR: begin
          if (cnt_q == BIT_LAST) begin
            // A frame met during programming is dropped like a stranger's.
            if (byte_v == {ADDR_FIXED, addr_pin_hi, addr_pin_lo} &&
                !busy_q) begin
              st_d = DS_INSTR;
            end else begin
              st_d = DS_SKIP;
            end
          end
        end
        DS_INSTR: begin
          if (cnt_q == BIT_LAST) begin
            instr_d = byte_v;
            if (byte_v[7:2] == OP_STEP) begin
              st_d = DS_STEP;
            end else begin
              st_d = DS_SKIP;
              have_d = 1'b1;
            end
          end
        end
        DS_STEP: begin
          // Wipers stop at the ends instead of wrapping round.
          if (spi.si) begin
            if (wiper_q[step_pp] != WIPER_MAX) begin
              wiper_d[step_pp] = wiper_q[step_pp] + 6'h01;
            end
          end else begin
            if (wiper_q[step_pp] != WIPER_RST) begin
              wiper_d[step_pp] = wiper_q[step_pp] - 6'h01;
            end
          end
        end
        DS_SKIP: begin
          // A clock past the instruction byte spoils a transfer frame.
          have_d = 1'b0;
        end
        default: begin
          st_d = DS_SKIP;
        end
      endcase
    end

    // Transfers act only once the frame closes with chip select high.
    if (cs_rise && have_q) begin
      case (instr_q[7:4])
        OP_GRESTORE: begin
          if (pp == 2'h0) begin
            for (int p = 0; p < NUM_POTS; p++) begin
              wiper_d[p] = slot_q[p][rr];
            end
          end
        end
        OP_GSAVE: begin
          if (pp == 2'h0) begin
            for (int p = 0; p < NUM_POTS; p++) begin
              slot_d[p][rr] = wiper_q[p];
            end
            busy_d = 1'b1;
            bcnt_d = T_WR_LOAD;
          end
        end
        OP_SAVE: begin
          slot_d[pp][rr] = wiper_q[pp];
          busy_d = 1'b1;
          bcnt_d = T_WR_LOAD;
        end
        OP_RESTORE: begin
          wiper_d[pp] = slot_q[pp][rr];
        end
        default: begin
          wiper_d = wiper_q;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= DS_ADDR;
      cnt_q <= 3'h0;
      sh_q <= 7'h00;
      instr_q <= 8'h00;
      have_q <= 1'b0;
      sclk_q <= 1'b0;
      csn_q <= 1'b1;
      wiper_q <= {NUM_POTS{WIPER_RST}};
      slot_q <= {(NUM_POTS * NUM_SLOTS){WIPER_RST}};
      busy_q <= 1'b0;
      bcnt_q <= 32'h0000_0000;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      instr_q <= instr_d;
      have_q <= have_d;
      sclk_q <= spi.sclk;
      csn_q <= spi.cs_n;
      wiper_q <= wiper_d;
      slot_q <= slot_d;
      busy_q <= busy_d;
      bcnt_q <= bcnt_d;
    end
  end

  assign live_wiper_setting = wiper_q;
  assign stored_setting_slot = slot_q;
  assign programming_busy_flag = busy_q;
endmodule

// >>> src/ptsd_host.sv
// Host end: AXI4-Lite register slave that drives frames onto the link.
`timescale 1ns/1ns
module ptsd_host
  import ptsd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  ptsd_spi_if.host spi,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic aw_got_q;
  logic aw_got_d;
  logic w_got_q;
  logic w_got_d;
  logic [3:0] awaddr_q;
  logic [3:0] awaddr_d;
  logic [31:0] wdata_q;
  logic [31:0] wdata_d;
  logic [3:0] wstrb_q;
  logic [3:0] wstrb_d;
  logic bvalid_q;
  logic bvalid_d;
  logic [1:0] bresp_q;
  logic [1:0] bresp_d;
  logic rvalid_q;
  logic rvalid_d;
  logic [1:0] rresp_q;
  logic [1:0] rresp_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [12:0] frame_q;
  logic [12:0] frame_d;
  logic [31:0] steps_q;
  logic [31:0] steps_d;
  logic [1:0] devaddr_q;
  logic [1:0] devaddr_d;
  logic start;
  logic [31:0] wmask;
  logic [31:0] wmerge_frame;
  logic [31:0] wmerge_steps;
  logic [31:0] wmerge_cfg;

  ptsd_hst_t hst_q;
  ptsd_hst_t hst_d;
  logic [5:0] idx_q;
  logic [5:0] idx_d;
  logic [2:0] div_q;
  logic [2:0] div_d;
  logic sclk_q;
  logic sclk_d;
  logic csn_q;
  logic csn_d;
  logic si_q;
  logic si_d;
  logic [15:0] hdr;
  logic [5:0] last_idx;
  logic [5:0] next_idx;
  logic [5:0] step_off;
  logic bit_next;

  for (genvar i = 0; i < 4; i++) begin : g_strb
    assign wmask[8*i +: 8] = {8{wstrb_q[i]}};
  end

  assign wmerge_frame = ({19'h0, frame_q} & ~wmask) | (wdata_q & wmask);
  assign wmerge_steps = (steps_q & ~wmask) | (wdata_q & wmask);
  assign wmerge_cfg = ({30'h0, devaddr_q} & ~wmask) | (wdata_q & wmask);

  assign s_axi_awready = ~aw_got_q & ~bvalid_q;
  assign s_axi_wready = ~w_got_q & ~bvalid_q;
  assign s_axi_arready = ~rvalid_q;

  always_comb begin
    aw_got_d = aw_got_q | (s_axi_awvalid & s_axi_awready);
    w_got_d = w_got_q | (s_axi_wvalid & s_axi_wready);
    awaddr_d = (s_axi_awvalid & s_axi_awready) ? s_axi_awaddr : awaddr_q;
    wdata_d = (s_axi_wvalid & s_axi_wready) ? s_axi_wdata : wdata_q;
    wstrb_d = (s_axi_wvalid & s_axi_wready) ? s_axi_wstrb : wstrb_q;
    bvalid_d = bvalid_q & ~s_axi_bready;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q & ~s_axi_rready;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    frame_d = frame_q;
    steps_d = steps_q;
    devaddr_d = devaddr_q;
    start = 1'b0;
    if (aw_got_q && w_got_q && !bvalid_q) begin
      aw_got_d = 1'b0;
      w_got_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = RESP_OKAY;
      case (awaddr_q)
        REG_FRAME: begin
          // Writing the frame register launches it; a busy link drops it.
          if (hst_q == HS_IDLE) begin
            frame_d = wmerge_frame[12:0];
            start = 1'b1;
          end
        end
        REG_STEPS: steps_d = wmerge_steps;
        REG_CFG: devaddr_d = wmerge_cfg[1:0];
        REG_STATUS: bresp_d = RESP_OKAY;
        default: bresp_d = RESP_SLVERR;
      endcase
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      case (s_axi_araddr)
        REG_FRAME: rdata_d = {19'h0, frame_q};
        REG_STEPS: rdata_d = steps_q;
        REG_CFG: rdata_d = {30'h0, devaddr_q};
        REG_STATUS: rdata_d = {31'h0, hst_q != HS_IDLE};
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      frame_q <= FRAME_RST;
      steps_q <= STEPS_RST;
      devaddr_q <= CFG_RST;
    end else begin
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      frame_q <= frame_d;
      steps_q <= steps_d;
      devaddr_q <= devaddr_d;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  // Address byte then instruction byte go out MSB first; steps LSB first.
  assign hdr = {ADDR_FIXED, devaddr_q, frame_q[7:0]};
  assign last_idx = {1'b0, frame_q[12:8]} + 6'h0f;
  assign next_idx = idx_q + 6'h01;
  assign step_off = next_idx - 6'h10;
  assign bit_next = (next_idx < 6'h10) ? hdr[4'hf - next_idx[3:0]]
                                       : steps_q[step_off[4:0]];

  always_comb begin
    hst_d = hst_q;
    idx_d = idx_q;
    div_d = div_q;
    sclk_d = sclk_q;
    csn_d = csn_q;
    si_d = si_q;
    case (hst_q)
      HS_IDLE: begin
        if (start) begin
          hst_d = HS_SHIFT;
          idx_d = 6'h00;
          div_d = 3'h0;
          csn_d = 1'b0;
          si_d = ADDR_FIXED[5];
        end
      end
      HS_SHIFT: begin
        if (div_q == {1'b0, SCLK_HALF_CYC} - 3'h1) begin
          div_d = 3'h0;
          if (!sclk_q) begin
            sclk_d = 1'b1;
          end else begin
            sclk_d = 1'b0;
            if (idx_q == last_idx) begin
              // Deselect after the last high phase closes every frame.
              hst_d = HS_GAP;
              csn_d = 1'b1;
            end else begin
              idx_d = next_idx;
              si_d = bit_next;
            end
          end
        end else begin
          div_d = div_q + 3'h1;
        end
      end
      HS_GAP: begin
        if (div_q == CS_GAP_CYC - 3'h1) begin
          hst_d = HS_IDLE;
          div_d = 3'h0;
        end else begin
          div_d = div_q + 3'h1;
        end
      end
      default: begin
        hst_d = HS_IDLE;
        csn_d = 1'b1;
        sclk_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hst_q <= HS_IDLE;
      idx_q <= 6'h00;
      div_q <= 3'h0;
      sclk_q <= 1'b0;
      csn_q <= 1'b1;
      si_q <= 1'b0;
    end else begin
      hst_q <= hst_d;
      idx_q <= idx_d;
      div_q <= div_d;
      sclk_q <= sclk_d;
      csn_q <= csn_d;
      si_q <= si_d;
    end
  end

  assign spi.cs_n = csn_q;
  assign spi.sclk = sclk_q;
  assign spi.si = si_q;
endmodule

// >>> verification/ptsd_link_props.sv
// Assertions on the serial link and the device outputs it controls.
`timescale 1ns/1ns
module ptsd_link_props
  import ptsd_pkg::*;
#(
  parameter int unsigned T_WR_CYC = 20
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic si,
  input wire logic [NUM_POTS*WIPER_W-1:0] live_wiper_setting,
  input wire logic [NUM_POTS*NUM_SLOTS*WIPER_W-1:0] stored_setting_slot,
  input wire logic programming_busy_flag
);
  logic [31:0] busy_cnt_q;
  logic [31:0] busy_cnt_d;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  always_comb begin
    busy_cnt_d = programming_busy_flag ? busy_cnt_q + 32'h1 : 32'h0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_cnt_q <= 32'h0;
    end else begin
      busy_cnt_q <= busy_cnt_d;
    end
  end

  sequence s_sclk_high;
    sclk [*2] ##1 !sclk;
  endsequence

  sequence s_cs_gap;
    cs_n [*4];
  endsequence

  AST_SCLK_IDLE: assert property (cs_n |-> !sclk)
    else $error("serial clock active while deselected");
  AST_SCLK_PHASE: assert property ($rose(sclk) |-> s_sclk_high)
    else $error("serial clock high phase length wrong");
  AST_CS_GAP: assert property ($rose(cs_n) |-> s_cs_gap)
    else $error("deselect gap too short");
  AST_SI_EDGE: assert property (
    !$stable(si) |-> $fell(sclk) || $fell(cs_n) || cs_n)
    else $error("serial data moved away from falling clock");
  AST_PROG_AFTER_CS: assert property (
    $rose(programming_busy_flag) |-> $past(cs_n))
    else $error("programming began inside a frame");
  AST_BUSY_LEN: assert property (
    $fell(programming_busy_flag) |-> busy_cnt_q == T_WR_CYC)
    else $error("write cycle length wrong");
  AST_SLOT_WRITE: assert property (
    !$stable(stored_setting_slot) |-> $rose(programming_busy_flag))
    else $error("stored slot changed without programming");
  // The device sees a link edge in the cycle it arrives and acts one cycle after.
  AST_WIPER_CAUSE: assert property (
    !$stable(live_wiper_setting) |->
      ($past(sclk) && !$past(sclk, 2)) ||
      ($past(cs_n) && !$past(cs_n, 2)))
    else $error("wiper changed without a step or transfer");
endmodule

// >>> verification/tb.sv
// Testbench joining host and device ends through the serial link.
`timescale 1ns/1ns
module tb;
  import ptsd_pkg::*;
  localparam int unsigned TWR = 20;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, busy;
  logic [1:0] bresp;
  logic [1:0] rresp;
  logic [31:0] rdata;
  logic [23:0] live;
  logic [95:0] slots;
  int failures = 0;
  int total_checks = 0;

  ptsd_spi_if link ();

  always #10 aclk = ~aclk;

  ptsd_host ptsd_host_inst (.aclk(aclk), .aresetn(aresetn), .spi(link),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  ptsd_device #(.T_WR_CYC(TWR)) ptsd_device_inst (.aclk(aclk),
    .aresetn(aresetn), .spi(link), .addr_pin_hi(1'b1),
    .addr_pin_lo(1'b0), .live_wiper_setting(live),
    .stored_setting_slot(slots), .programming_busy_flag(busy));

  ptsd_link_props #(.T_WR_CYC(TWR)) ptsd_link_props_inst (.aclk(aclk),
    .aresetn(aresetn), .cs_n(link.cs_n), .sclk(link.sclk), .si(link.si),
    .live_wiper_setting(live), .stored_setting_slot(slots),
    .programming_busy_flag(busy));

  task automatic summarize();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  // A wait that ran out of its bound ends the run as a failure.
  task automatic guard(input int i);
    if (i >= 200) begin
      failures++;
      summarize();
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    int i;
    logic aw;
    logic w;
    i = 0;
    aw = 1'b1;
    w = 1'b1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      i++;
      if (aw && awready === 1'b1) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready === 1'b1) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end while ((aw || w) && i < 200);
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      i++;
    end while (bvalid !== 1'b1 && i < 200);
    r = bresp;
    bready <= 1'b0;
    guard(i);
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int i;
    i = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      i++;
    end while (arready !== 1'b1 && i < 200);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      i++;
    end while (rvalid !== 1'b1 && i < 200);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    guard(i);
  endtask

  // Polls the link flag so the device has acted before anything is compared.
  task automatic frame(input logic [7:0] ins, input logic [4:0] n,
                       input logic [31:0] st);
    int i;
    logic [31:0] d;
    logic [1:0] r;
    i = 0;
    wr(REG_STEPS, st, r);
    wr(REG_FRAME, {19'h0, n, ins}, r);
    do begin
      rd(REG_STATUS, d, r);
      i++;
    end while (d[0] !== 1'b0 && i < 200);
    guard(i);
    repeat (4) @(posedge aclk);
  endtask

  task automatic waitb();
    int i;
    i = 0;
    while (busy !== 1'b0 && i < 200) begin
      @(posedge aclk);
      i++;
    end
    guard(i);
  endtask

  function automatic logic [31:0] wp(input int p);
    return {26'h0, live[6*p +: 6]};
  endfunction

  function automatic logic [31:0] sl(input int p, input int s);
    return {26'h0, slots[(4*p+s)*6 +: 6]};
  endfunction

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    wr(4'h2, 32'h1, r);
    chk("unmapped bresp", {30'h0, r}, {30'h0, RESP_SLVERR});
    wr(REG_CFG, 32'h2, r);
    chk("cfg bresp", {30'h0, r}, {30'h0, RESP_OKAY});
    rd(REG_CFG, d, r);
    chk("cfg", d, 32'h2);
    chk("cfg rresp", {30'h0, r}, {30'h0, RESP_OKAY});
    rd(4'h2, d, r);
    chk("unmapped rdata", d, 32'h0);
    chk("unmapped rresp", {30'h0, r}, {30'h0, RESP_SLVERR});
    frame(8'h21, 5'h05, 32'h1f);
    chk("step up", wp(1), 32'h5);
    frame(8'h21, 5'h03, 32'h0);
    chk("step down", wp(1), 32'h2);
    frame(8'h23, 5'h04, 32'hf);
    chk("pot3 up", wp(3), 32'h4);
    frame(8'he9, 5'h00, 32'h0);
    chk("save busy", {31'h0, busy}, 32'h1);
    chk("save slot", sl(1, 2), 32'h2);
    waitb();
    frame(8'h21, 5'h07, 32'h7f);
    chk("step up again", wp(1), 32'h9);
    frame(8'hd9, 5'h00, 32'h0);
    chk("restore", wp(1), 32'h2);
    chk("restore busy", {31'h0, busy}, 32'h0);
    frame(8'h8c, 5'h00, 32'h0);
    chk("gsave p1", sl(1, 3), 32'h2);
    chk("gsave p3", sl(3, 3), 32'h4);
    waitb();
    frame(8'h10, 5'h00, 32'h0);
    chk("grestore slot0", wp(3), 32'h0);
    frame(8'h1c, 5'h00, 32'h0);
    chk("grestore p3", wp(3), 32'h4);
    chk("grestore p1", wp(1), 32'h2);
    frame(8'h11, 5'h00, 32'h0);
    chk("grestore low bits", wp(3), 32'h4);
    frame(8'hd1, 5'h01, 32'h1);
    chk("restore extra clock", wp(1), 32'h2);
    repeat (3) frame(8'h22, 5'h1f, 32'h7fff_ffff);
    chk("step top", wp(2), 32'h3f);
    frame(8'h20, 5'h02, 32'h0);
    chk("step floor", wp(0), 32'h0);
    wr(REG_CFG, 32'h1, r);
    frame(8'h23, 5'h02, 32'h3);
    chk("wrong address", wp(3), 32'h4);
    summarize();
  end
endmodule
